// ---- adc_pkg.sv ----
// Shared register map, field positions, reset values and timing for the converter control.
package adc_pkg;
  localparam logic [7:0] PORT_A_PINS_ADDR = 8'h05;
  localparam logic [7:0] PORT_E_PINS_ADDR = 8'h09;
  localparam logic [7:0] INTERRUPT_CONTROL_ADDR = 8'h0B;
  localparam logic [7:0] PERIPHERAL_FLAGS_ADDR = 8'h0C;
  localparam logic [7:0] RESULT_HIGH_ADDR = 8'h1E;
  localparam logic [7:0] CONVERTER_CONTROL_ADDR = 8'h1F;
  localparam logic [7:0] PORT_A_DIRECTION_ADDR = 8'h85;
  localparam logic [7:0] PORT_E_DIRECTION_ADDR = 8'h89;
  localparam logic [7:0] PERIPHERAL_ENABLES_ADDR = 8'h8C;
  localparam logic [7:0] RESULT_LOW_ADDR = 8'h9E;
  localparam logic [7:0] CONVERTER_FORMAT_PINS_ADDR = 8'h9F;

  localparam logic [5:0] PORT_A_DIR_RESET = 6'h3F;
  localparam logic [2:0] PORT_E_DIR_RESET = 3'h7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int CLK_SEL_MSB = 7;
  localparam int CLK_SEL_LSB = 6;
  localparam int CHAN_MSB = 5;
  localparam int CHAN_LSB = 3;
  localparam int GO_BIT = 2;
  localparam int ON_BIT = 0;
  localparam int FORMAT_BIT = 7;
  localparam int DONE_FLAG_BIT = 6;
  localparam int DONE_ENABLE_BIT = 6;
  localparam int GLOBAL_IRQ_BIT = 7;
  localparam int PERIPH_IRQ_BIT = 6;

  localparam logic [1:0] CLK_SEL_TOSC2 = 2'h0;
  localparam logic [1:0] CLK_SEL_TOSC8 = 2'h1;
  localparam logic [1:0] CLK_SEL_TOSC32 = 2'h2;
  localparam logic [1:0] CLK_SEL_RC = 2'h3;

  localparam int CLK_PERIOD_NS = 40;
  localparam int RC_TAD_NS = 4000;
  localparam int RC_TAD_CYCLES = RC_TAD_NS / CLK_PERIOD_NS;
  localparam int TOSC2_CYCLES = 2;
  localparam int TOSC8_CYCLES = 8;
  localparam int TOSC32_CYCLES = 32;
  localparam logic [2:0] TCY_CYCLES = 3'h4;
  localparam logic [3:0] LAST_TAD = 4'hB;
endpackage : adc_pkg

// ---- tad_tick.sv ----
// Conversion bit-period tick generator for the four clock selections.
`timescale 1ns/1ps
module tad_tick (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } tick_state_type;

  tick_state_type q;
  tick_state_type n;
  logic [6:0] period;

  always_comb
  begin
    case (sel)
      adc_pkg::CLK_SEL_TOSC2: period = 7'(adc_pkg::TOSC2_CYCLES);
      adc_pkg::CLK_SEL_TOSC8: period = 7'(adc_pkg::TOSC8_CYCLES);
      adc_pkg::CLK_SEL_TOSC32: period = 7'(adc_pkg::TOSC32_CYCLES);
      default: period = 7'(adc_pkg::RC_TAD_CYCLES);
    endcase
    n = q;
    n.tick = 1'b0;
    if (!run)
    begin
      n.cnt = 7'h00;
    end
    else if (q.cnt >= period - 7'h01)
    begin
      n.cnt = 7'h00;
      n.tick = 1'b1;
    end
    else
    begin
      n.cnt = q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else if (clk_en)
      q <= n;
  end

  assign tick = q.tick;

  // With CLK_SEL_TOSC8 selected, a tick must follow exactly eight clocks after the previous one while nothing pauses it.
  tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && run && q.tick && sel == adc_pkg::CLK_SEL_TOSC8
      ##1 (clk_en && run && sel == adc_pkg::CLK_SEL_TOSC8)[*7] |=> q.tick)
    else $error("Bit-period counter did not restart on tick.");
endmodule : tad_tick

// ---- sar_core.sv ----
// Successive-approximation sequencer producing ten result bits from the comparator.
`timescale 1ns/1ps
module sar_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic comp,
  output logic busy,
  output logic done,
  output logic [9:0] result,
  output logic [9:0] dac_code,
  output logic hold_open
);
  typedef enum logic {IDLE, CONVERT} sar_state_type;
  typedef struct packed {
    sar_state_type st;
    logic [3:0] cnt;
    logic [9:0] sar;
    logic [9:0] res;
    logic done;
    logic hold_open;
  } sar_reg_type;

  sar_reg_type q;
  sar_reg_type n;
  logic [9:0] trial;

  always_comb
  begin
    trial = 10'(10'h200 >> (q.cnt - 4'h2));
    n = q;
    n.done = 1'b0;
    case (q.st)
      IDLE:
      begin
        if (start)
        begin
          n.st = CONVERT;
          n.cnt = 4'h0;
          n.sar = 10'h000;
        end
      end
      default:
      begin
        if (abort)
        begin
          n.st = IDLE;
          n.sar = 10'h000;
          n.hold_open = 1'b0;
        end
        else if (tick)
        begin
          n.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'h1)
          begin
            n.hold_open = 1'b1;
            n.sar = 10'h200;
          end
          else if (q.cnt >= 4'h2)
          begin
            n.sar = (q.sar & ~trial) | (comp ? trial : 10'h000) | (trial >> 1);
          end
          if (q.cnt == adc_pkg::LAST_TAD)
          begin
            n.st = IDLE;
            n.done = 1'b1;
            n.hold_open = 1'b0;
            n.res = (q.sar & ~trial) | (comp ? trial : 10'h000);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else if (clk_en)
      q <= n;
  end

  assign busy = (q.st == CONVERT);
  assign done = q.done;
  assign result = q.res;
  assign dac_code = q.sar;
  assign hold_open = q.hold_open;

  full_length_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(clk_en) && q.done |-> $past(q.cnt) == adc_pkg::LAST_TAD && $past(q.st) == CONVERT)
    else $error("Conversion finished before twelve bit periods.");
endmodule : sar_core

// ---- adc_sleep_reset_control.sv ----
// Converter control: register file, halt behaviour, abort, result format and interrupt.
`timescale 1ns/1ps
// Notes on behaviour
// - Conversion continues during halt only with the RC bit clock selected.
// - With RC clock, start waits one instruction cycle after go is set.
// - Conversion finishing in halt clears go and loads the result pair.
// - Finished conversion wakes the device when its interrupt enable is set.
// - Without enable, converter powers down after conversion in halt; on bit stays.
// - Halt with non-RC clock aborts conversion, powers down, on bit stays.
// - Powered-down converter stops all bit clocks and conversion activity.
// - Reset restores registers, powers converter off, aborts any conversion.
// - Reset leaves the result pair untouched.
// - Clearing go mid-conversion aborts it; result pair keeps old value.
// - Clock select 00/01/10 give 2/8/32 oscillator periods, 11 is RC.
// - Conversion spans twelve bit periods, deciding bits from MSB down.
// - Format bit left- or right-justifies the result, zero filling the rest.
module adc_sleep_reset_control (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic cpu_halted,
  input wire logic comp_in,
  input wire logic [5:0] port_a_in,
  output logic [5:0] port_a_out,
  output logic [5:0] port_a_oe,
  input wire logic [2:0] port_e_in,
  output logic [2:0] port_e_out,
  output logic [2:0] port_e_oe,
  output logic [2:0] channel_select,
  output logic [3:0] analog_pin_config,
  output logic [9:0] dac_code,
  output logic hold_open,
  output logic converter_powered,
  output logic irq,
  output logic wake_req
);
  typedef struct packed {
    logic [9:0] pin_meta;
    logic [9:0] pin_sync;
    logic [7:0] rdata;
    logic [5:0] pa_lat;
    logic [5:0] pa_dir;
    logic [2:0] pe_lat;
    logic [2:0] pe_dir;
    logic [5:0] pa_oe;
    logic [2:0] pe_oe;
    logic [7:0] int_ctl;
    logic flag;
    logic [7:0] enables;
    logic [1:0] clk_sel;
    logic [2:0] chan;
    logic go;
    logic on;
    logic fmt;
    logic [3:0] pcfg;
    logic [2:0] dly;
    logic start;
    logic halted_off;
    logic powered;
    logic irq;
    logic wake;
  } ctl_type;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } result_pair_type;

  ctl_type q;
  ctl_type n;
  result_pair_type keep_q;
  result_pair_type keep_d;
  logic rst_meta;
  logic rst_n;
  logic rc_sel;
  logic tick;
  logic sar_busy;
  logic sar_done;
  logic [9:0] sar_result;
  logic wr_ctrl;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  tad_tick u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .run(q.on && !q.halted_off && (!cpu_halted || rc_sel)),
    .sel(q.clk_sel),
    .tick(tick)
  );

  sar_core u_sar (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(q.start),
    .abort(!q.go || !q.on || q.halted_off),
    .tick(tick),
    .comp(q.pin_sync[9]),
    .busy(sar_busy),
    .done(sar_done),
    .result(sar_result),
    .dac_code(dac_code),
    .hold_open(hold_open)
  );

  assign rc_sel = (q.clk_sel == adc_pkg::CLK_SEL_RC);
  assign wr_ctrl = wr_en && addr == adc_pkg::CONVERTER_CONTROL_ADDR;

  always_comb
  begin
    n = q;
    keep_d = keep_q;
    n.pin_meta = {comp_in, port_e_in, port_a_in};
    n.pin_sync = q.pin_meta;
    n.start = 1'b0;
    n.rdata = 8'h00;
    if (q.dly != 3'h0)
    begin
      n.dly = q.dly - 3'h1;
      n.start = (q.dly == 3'h1);
    end
    if (wr_en)
    begin
      if (addr == adc_pkg::PORT_A_PINS_ADDR)
        n.pa_lat = wdata[5:0];
      else if (addr == adc_pkg::PORT_E_PINS_ADDR)
        n.pe_lat = wdata[2:0];
      else if (addr == adc_pkg::INTERRUPT_CONTROL_ADDR)
        n.int_ctl = wdata;
      else if (addr == adc_pkg::PERIPHERAL_FLAGS_ADDR)
        n.flag = q.flag && !wdata[adc_pkg::DONE_FLAG_BIT];
      else if (addr == adc_pkg::RESULT_HIGH_ADDR)
        keep_d.hi = wdata;
      else if (addr == adc_pkg::PORT_A_DIRECTION_ADDR)
        n.pa_dir = wdata[5:0];
      else if (addr == adc_pkg::PORT_E_DIRECTION_ADDR)
        n.pe_dir = wdata[2:0];
      else if (addr == adc_pkg::PERIPHERAL_ENABLES_ADDR)
        n.enables = wdata;
      else if (addr == adc_pkg::RESULT_LOW_ADDR)
        keep_d.lo = wdata;
      else if (addr == adc_pkg::CONVERTER_FORMAT_PINS_ADDR)
      begin
        n.fmt = wdata[adc_pkg::FORMAT_BIT];
        n.pcfg = wdata[3:0];
      end
    end
    if (wr_ctrl)
    begin
      n.clk_sel = wdata[adc_pkg::CLK_SEL_MSB:adc_pkg::CLK_SEL_LSB];
      n.chan = wdata[adc_pkg::CHAN_MSB:adc_pkg::CHAN_LSB];
      n.on = wdata[adc_pkg::ON_BIT];
      if (!wdata[adc_pkg::GO_BIT] || !wdata[adc_pkg::ON_BIT])
      begin
        // Dropping go also cancels a pending RC start.
        n.go = 1'b0;
        n.dly = 3'h0;
        n.start = 1'b0;
      end
      else if (!q.go && q.on && !sar_busy)
      begin
        // Go in the same write that turns the converter on is ignored.
        n.go = 1'b1;
        if (wdata[adc_pkg::CLK_SEL_MSB:adc_pkg::CLK_SEL_LSB] == adc_pkg::CLK_SEL_RC)
          n.dly = adc_pkg::TCY_CYCLES;
        else
          n.start = 1'b1;
      end
    end
    if (sar_done)
    begin
      n.go = 1'b0;
      n.flag = 1'b1;
      if (q.fmt)
      begin
        keep_d.hi = {6'h00, sar_result[9:8]};
        keep_d.lo = sar_result[7:0];
      end
      else
      begin
        keep_d.hi = sar_result[9:2];
        keep_d.lo = {sar_result[1:0], 6'h00};
      end
      if (cpu_halted && !q.enables[adc_pkg::DONE_ENABLE_BIT])
        n.halted_off = 1'b1;
    end
    if (cpu_halted && !rc_sel)
    begin
      n.go = 1'b0;
      n.dly = 3'h0;
      n.start = 1'b0;
      n.halted_off = 1'b1;
    end
    if (!cpu_halted)
      n.halted_off = 1'b0;
    n.powered = n.on && !n.halted_off;
    n.pa_oe = ~n.pa_dir;
    n.pe_oe = ~n.pe_dir;
    n.wake = n.flag && n.enables[adc_pkg::DONE_ENABLE_BIT];
    n.irq = n.wake && n.int_ctl[adc_pkg::GLOBAL_IRQ_BIT] && n.int_ctl[adc_pkg::PERIPH_IRQ_BIT];
    if (rd_en)
    begin
      if (addr == adc_pkg::PORT_A_PINS_ADDR)
        n.rdata = {2'h0, q.pin_sync[5:0]};
      else if (addr == adc_pkg::PORT_E_PINS_ADDR)
        n.rdata = {5'h00, q.pin_sync[8:6]};
      else if (addr == adc_pkg::INTERRUPT_CONTROL_ADDR)
        n.rdata = q.int_ctl;
      else if (addr == adc_pkg::PERIPHERAL_FLAGS_ADDR)
        n.rdata = {1'b0, q.flag, 6'h00};
      else if (addr == adc_pkg::RESULT_HIGH_ADDR)
        n.rdata = keep_q.hi;
      else if (addr == adc_pkg::CONVERTER_CONTROL_ADDR)
        n.rdata = {q.clk_sel, q.chan, q.go, 1'b0, q.on};
      else if (addr == adc_pkg::PORT_A_DIRECTION_ADDR)
        n.rdata = {2'h0, q.pa_dir};
      else if (addr == adc_pkg::PORT_E_DIRECTION_ADDR)
        n.rdata = {5'h00, q.pe_dir};
      else if (addr == adc_pkg::PERIPHERAL_ENABLES_ADDR)
        n.rdata = q.enables;
      else if (addr == adc_pkg::RESULT_LOW_ADDR)
        n.rdata = keep_q.lo;
      else if (addr == adc_pkg::CONVERTER_FORMAT_PINS_ADDR)
        n.rdata = {q.fmt, 3'h0, q.pcfg};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.pa_dir <= adc_pkg::PORT_A_DIR_RESET;
      q.pe_dir <= adc_pkg::PORT_E_DIR_RESET;
    end
    else if (clk_en)
      q <= n;
  end

  // The result pair has no reset so a warm reset keeps the last conversion.
  always_ff @(posedge clk)
  begin
    if (clk_en)
      keep_q <= keep_d;
  end

  assign rdata = q.rdata;
  assign port_a_out = q.pa_lat;
  assign port_a_oe = q.pa_oe;
  assign port_e_out = q.pe_lat;
  assign port_e_oe = q.pe_oe;
  assign channel_select = q.chan;
  assign analog_pin_config = q.pcfg;
  assign converter_powered = q.powered;
  assign irq = q.irq;
  assign wake_req = q.wake;

  halt_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && $past(clk_en) && tick && $past(cpu_halted) |-> $past(rc_sel))
    else $error("Bit clock ran during halt without RC select.");
  rc_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && $rose(q.go) && rc_sel ##1 clk_en[*4] |-> q.start || !q.go)
    else $error("RC start did not follow one instruction cycle.");
  done_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sar_done |=> !q.go && keep_q == ($past(q.fmt) ? {6'h00, $past(sar_result)}
      : {$past(sar_result), 6'h00}))
    else $error("Completion left go set or result unloaded.");
  wake_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sar_done && q.enables[adc_pkg::DONE_ENABLE_BIT] |=> wake_req)
    else $error("Completion with enable did not request wake.");
  halt_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sar_done && cpu_halted && !q.enables[adc_pkg::DONE_ENABLE_BIT] && !wr_ctrl
      |=> q.halted_off && q.on == $past(q.on) && !converter_powered)
    else $error("Converter not powered down after halted conversion.");
  halt_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cpu_halted && !rc_sel && sar_busy ##1 clk_en |-> !q.go ##1 !sar_busy)
    else $error("Halt with non-RC clock did not abort.");
  off_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && q.halted_off |=> !tick)
    else $error("Bit clock running while converter is off.");
  reset_state_a: assert property (@(posedge clk)
    $rose(rst_n) |-> !q.go && !q.on && !sar_busy && !converter_powered)
    else $error("Reset did not clear converter state.");
  abort_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sar_busy && !q.go && !wr_en |=> $stable(keep_q) && !sar_busy)
    else $error("Abort changed result or left conversion running.");
  format_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sar_done |=> ($past(q.fmt) ? keep_q.hi[7:2] == 6'h00 : keep_q.lo[5:0] == 6'h00))
    else $error("Result justification left stray bits.");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sar_done |=> q.flag)
    else $error("Completion did not set the done flag.");

  halted_conv_c: cover property (@(posedge clk) disable iff (!rst_n) sar_done && cpu_halted);
  abort_c: cover property (@(posedge clk) disable iff (!rst_n) sar_busy && !q.go);
  irq_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule : adc_sleep_reset_control

// ---- adc_sleep_reset_control_tb.sv ----
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module adc_sleep_reset_control_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic cpu_halted = 1'b0;
  logic comp_in = 1'b0;
  logic [5:0] port_a_in = 6'h15;
  logic [2:0] port_e_in = 3'h5;
  logic [7:0] rdata;
  logic [5:0] port_a_out;
  logic [5:0] port_a_oe;
  logic [2:0] port_e_out;
  logic [2:0] port_e_oe;
  logic [2:0] channel_select;
  logic [3:0] analog_pin_config;
  logic [9:0] dac_code;
  logic hold_open;
  logic converter_powered;
  logic irq;
  logic wake_req;
  logic [9:0] analog = 10'h000;
  logic [7:0] rd_q;
  logic [7:0] last_hi;
  logic [7:0] last_lo;
  int errors = 0;
  int tests_run = 0;
  int n;
  // Columns: operation (1 write, 0 read), address, write data, expected read data.
  localparam logic [27:0] ROWS [0:24] = '{28'h01F0000, 28'h00C0000, 28'h085003F, 28'h0890007,
    28'h08C0000, 28'h09F0000, 28'h00B0000, 28'h0400000, 28'h0050015, 28'h0090005,
    28'h140FF00, 28'h0400000, 28'h1850000, 28'h0850000, 28'h1052A00, 28'h1890000,
    28'h0890000, 28'h10B3C00, 28'h00B003C, 28'h19F0F00, 28'h09F000F, 28'h11F3800,
    28'h01F0038, 28'h11F3C00, 28'h01F0038};
  localparam logic [9:0] VALS [0:2] = '{10'h2A5, 10'h2A5, 10'h155};

  always #20 clk = ~clk;

  // The comparator sees the trial code one clock late, as a real pin would.
  always @(posedge clk)
  begin
    comp_in <= (analog >= dac_code);
  end

  adc_sleep_reset_control dut_u (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cpu_halted(cpu_halted),
    .comp_in(comp_in), .port_a_in(port_a_in), .port_a_out(port_a_out),
    .port_a_oe(port_a_oe), .port_e_in(port_e_in), .port_e_out(port_e_out),
    .port_e_oe(port_e_oe), .channel_select(channel_select),
    .analog_pin_config(analog_pin_config), .dac_code(dac_code), .hold_open(hold_open),
    .converter_powered(converter_powered), .irq(irq), .wake_req(wake_req)
  );

  task test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk8

  task chk1(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : chk1

  task chk_range(input int got, input int lo, input int hi, input string msg);
    tests_run++;
    if (got < lo || got > hi)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s took %0d, allowed %0d..%0d", $time, msg, got, lo, hi);
    end
  endtask : chk_range

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rd_q = rdata;
  endtask : rd

  function automatic int tad(input logic [1:0] sel);
    case (sel)
      2'h0: return adc_pkg::TOSC2_CYCLES;
      2'h1: return adc_pkg::TOSC8_CYCLES;
      2'h2: return adc_pkg::TOSC32_CYCLES;
      default: return adc_pkg::RC_TAD_CYCLES;
    endcase
  endfunction : tad

  task start_conv(input logic [1:0] sel, input logic fmt);
    wr(8'h9F, {fmt, 7'h00});
    wr(8'h1F, {sel, 6'h01});
    wr(8'h1F, {sel, 6'h05});
  endtask : start_conv

  // Polls the done flag; each read costs two clocks.
  task wait_done;
    n = 0;
    rd_q = 8'h00;
    while (rd_q[6] !== 1'b1 && n < 3000)
    begin
      rd(8'h0C);
      n += 2;
    end
  endtask : wait_done

  task chk_res(input logic fmt, input logic [9:0] r);
    last_hi = fmt ? {6'h00, r[9:8]} : r[9:2];
    last_lo = fmt ? r[7:0] : {r[1:0], 6'h00};
    rd(8'h1E);
    chk8(rd_q, last_hi, "result high");
    rd(8'h9E);
    chk8(rd_q, last_lo, "result low");
  endtask : chk_res

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 25; i++)
    begin
      if (ROWS[i][24])
        wr(ROWS[i][23:16], ROWS[i][15:8]);
      else
      begin
        rd(ROWS[i][23:16]);
        chk8(rd_q, ROWS[i][7:0], "register access");
      end
    end
    chk8({2'h0, port_a_oe}, 8'h3F, "port a drive");
    chk8({2'h0, port_a_out}, 8'h2A, "port a latch");
    chk8({5'h00, port_e_oe}, 8'h07, "port e drive");
    wr(8'h09, 8'h06);
    #1 chk8({5'h00, port_e_out}, 8'h06, "port e latch");
    chk8({4'h0, analog_pin_config}, 8'h0F, "pin config");
    chk8({5'h00, channel_select}, 8'h07, "channel");
    wr(8'h85, 8'h3F);
    wr(8'h89, 8'h07);
    wr(8'h0B, 8'h00);
    wr(8'h1F, 8'h00);
    wr(8'h8C, 8'h40);
    for (int s = 0; s < 3; s++)
    begin
      analog = VALS[s];
      start_conv(s[1:0], s[0]);
      wait_done();
      chk_range(n, 11 * tad(s[1:0]), 12 * tad(s[1:0]) + 24, "conversion time");
      if (s != 0)
        chk_res(s[0], VALS[s]);
      rd(8'h1F);
      chk8(rd_q, {s[1:0], 6'h01}, "go cleared");
      chk1(wake_req, 1'b1, "wake level");
      wr(8'h0C, 8'h40);
    end
    analog = 10'h0F0;
    start_conv(2'h1, 1'b0);
    repeat (30) @(posedge clk);
    wr(8'h1F, 8'h41);
    repeat (150) @(posedge clk);
    rd(8'h0C);
    chk8(rd_q, 8'h00, "abort flag");
    rd(8'h1E);
    chk8(rd_q, last_hi, "abort keeps high");
    analog = 10'h111;
    start_conv(2'h1, 1'b0);
    repeat (20) @(posedge clk);
    cpu_halted <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk1(converter_powered, 1'b0, "halt power");
    chk1(hold_open, 1'b0, "halt idle");
    chk1(|dac_code, 1'b0, "halt trial code");
    rd(8'h1F);
    chk8(rd_q, 8'h41, "halt on bit");
    repeat (150) @(posedge clk);
    rd(8'h0C);
    chk8(rd_q, 8'h00, "no conversion in halt");
    rd(8'h9E);
    chk8(rd_q, last_lo, "halt keeps low");
    @(posedge clk);
    cpu_halted <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk1(converter_powered, 1'b1, "power back");
    wr(8'h8C, 8'h00);
    analog = 10'h3C6;
    start_conv(2'h3, 1'b1);
    cpu_halted <= 1'b1;
    wait_done();
    chk_range(n, 11 * tad(2'h3) + 4, 12 * tad(2'h3) + 40, "rc conversion");
    repeat (2) @(posedge clk);
    #1 chk1(converter_powered, 1'b0, "rc off");
    chk1(wake_req, 1'b0, "masked wake");
    rd(8'h1F);
    chk8(rd_q, 8'hC1, "rc control");
    chk_res(1'b1, 10'h3C6);
    @(posedge clk);
    cpu_halted <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk1(converter_powered, 1'b1, "rc power back");
    wr(8'h0C, 8'h40);
    wr(8'h8C, 8'h40);
    analog = 10'h0A3;
    start_conv(2'h3, 1'b0);
    cpu_halted <= 1'b1;
    n = 0;
    while (wake_req !== 1'b1 && n < 3000)
    begin
      // Look after the edge has settled so the new level is seen.
      @(posedge clk);
      #1;
      n++;
    end
    chk_range(n, 11 * tad(2'h3) + 4, 12 * tad(2'h3) + 40, "wake time");
    #1 chk1(converter_powered, 1'b1, "awake power");
    chk_res(1'b0, 10'h0A3);
    @(posedge clk);
    cpu_halted <= 1'b0;
    wr(8'h0B, 8'hC0);
    repeat (2) @(posedge clk);
    #1 chk1(irq, 1'b1, "irq raised");
    wr(8'h8C, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk1(irq, 1'b0, "irq masked");
    wr(8'h8C, 8'h40);
    wr(8'h0C, 8'h40);
    repeat (2) @(posedge clk);
    #1 chk1(irq, 1'b0, "irq cleared");
    rd(8'h0C);
    chk8(rd_q, 8'h00, "flag cleared");
    // A write while the clock enable is low must leave the register untouched.
    @(posedge clk);
    clk_en <= 1'b0;
    wr(8'h8C, 8'h00);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(8'h8C);
    chk8(rd_q, 8'h40, "frozen write");
    wr(8'h0B, 8'h00);
    analog = 10'h200;
    start_conv(2'h1, 1'b0);
    repeat (30) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk1(converter_powered, 1'b0, "reset power");
    chk1(hold_open, 1'b0, "reset abort");
    chk1(|dac_code, 1'b0, "reset trial code");
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h1F);
    chk8(rd_q, 8'h00, "reset control");
    rd(8'h1E);
    chk8(rd_q, last_hi, "reset keeps high");
    rd(8'h9E);
    chk8(rd_q, last_lo, "reset keeps low");
    repeat (400) @(posedge clk);
    rd(8'h0C);
    chk8(rd_q, 8'h00, "no flag after reset");
    test_done();
  end
endmodule : adc_sleep_reset_control_tb
